//--- src/trig_seq_pkg.sv
// Constants, types and program layout for the trigger state sequencer
package trig_seq_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int NUM_STATES    = 16;
	localparam int STATE_W       = 4;
	localparam int NUM_CNT       = 4;
	localparam int CNT_SEL_W     = 2;
	localparam int CNT_W         = 16;
	localparam int NUM_FLAGS     = 4;
	localparam int NUM_PROBES    = 2;
	localparam int PROBE_W       = 8;
	localparam int CMP_PER_PROBE = 2;
	localparam int NUM_CMP       = NUM_PROBES * CMP_PER_PROBE;

	// ****************************************************************
	// Reset and arming values
	// ****************************************************************
	localparam logic [STATE_W-1:0]   FIRST_STATE = 4'h0;
	localparam logic [CNT_W-1:0]     CNT_ZERO    = 16'h0000;
	localparam logic [CNT_W-1:0]     CNT_ONE     = 16'h0001;
	localparam logic [NUM_FLAGS-1:0] FLAGS_IDLE  = 4'h0;
	localparam logic [PROBE_W-1:0]   PROBE_IDLE  = 8'h00;
	localparam int                   EDGE_BIT    = 0;

	// ****************************************************************
	// Probe comparator relations
	// ****************************************************************
	typedef enum logic [3:0] {
		CMP_EQ     = 4'h0,
		CMP_NE     = 4'h1,
		CMP_GT     = 4'h2,
		CMP_LT     = 4'h3,
		CMP_GE     = 4'h4,
		CMP_LE     = 4'h5,
		CMP_RISE   = 4'h6,
		CMP_FALL   = 4'h7,
		CMP_EITHER = 4'h8,
		CMP_STEADY = 4'h9
	} cmp_op_t;

	typedef enum logic [1:0] {
		BR_ONE   = 2'h0,
		BR_TWO   = 2'h1,
		BR_THREE = 2'h2
	} branch_t;

	typedef enum logic [1:0] {
		SEQ_RUN  = 2'b01,
		SEQ_HALT = 2'b10
	} seq_t;

	// ****************************************************************
	// Program records
	// ****************************************************************
	typedef struct packed {
		cmp_op_t            op;
		logic [PROBE_W-1:0] value;
		logic [PROBE_W-1:0] care;
	} probe_cmp_t;

	typedef struct packed {
		logic             ne;
		logic [CNT_W-1:0] value;
	} cnt_cmp_t;

	typedef struct packed {
		logic [NUM_CMP-1:0]   probe_sel;
		logic                 probe_or;
		logic                 cnt_en;
		logic [CNT_SEL_W-1:0] cnt_sel;
		logic                 cnt_or;
	} cond_t;

	typedef struct packed {
		logic [NUM_CNT-1:0]   cnt_clr;
		logic [NUM_CNT-1:0]   cnt_inc;
		logic [NUM_FLAGS-1:0] flag_set;
		logic [NUM_FLAGS-1:0] flag_clr;
		logic                 trigger;
		logic [STATE_W-1:0]   target;
	} action_t;

	typedef struct packed {
		branch_t kind;
		cond_t   cond_first;
		cond_t   cond_second;
		action_t act_first;
		action_t act_second;
		action_t act_default;
	} state_prog_t;

endpackage

//--- src/trigger_state_sequencer.sv
// Trigger state sequencer of the logic analyzer core
//
// Overview of operation
// (R1) Program holds up to 16 states, each a label with actions and branch.
// (R2) A state branches one way unconditionally, or two or three ways.
// (R3) Two-way: condition true takes first target, else alternative target.
// (R4) Three-way: first condition wins, then second, else default target.
// (R5) Goto moves to its target; each action block ends in goto or trigger.
// (R6) Four counters, each 16 bits, cleared, incremented and compared.
// (R7) A clear action sets the chosen counter to zero.
// (R8) An increment action adds one to the chosen counter.
// (R9) Four status flags, each set or cleared on its own by actions.
// (R10) The four flags are visible outside to watch program progress.
// (R11) Probe conditions only in branches; each uses its own comparator.
// (R12) Each probe has a build-time comparator count between 1 and 16.
// (R13) Probe comparators test ==, !=, >, <, >=, <= against a constant.
// (R14) Constants match probe width; each bit may be 0, 1 or don't-care.
// (R15) Single-bit probes also detect rise, fall, either edge or no edge.
// (R16) One comparator per counter, so each counter is tested once.
// (R17) Counter comparators test only equal and not equal, 16-bit constant.
// (R18) Probe terms in one condition all joined by AND or all by OR.
// (R19) Probe result joins one counter test by AND or OR independently.
// (R20) Starts in first state after reset or arming; steps once per cycle.
// (R21) Trigger pulses output one cycle, then sequencer holds until armed.
module trigger_state_sequencer (
	// Clock and reset
	input  wire logic                          CLK,
	input  wire logic                          RESET_N,
	// Arming
	input  wire logic                          ARM,
	// Probed user signals
	input  wire logic [trig_seq_pkg::NUM_PROBES-1:0]
	                  [trig_seq_pkg::PROBE_W-1:0] PROBE,
	// Program
	input  trig_seq_pkg::state_prog_t [trig_seq_pkg::NUM_STATES-1:0] PROGRAM,
	input  trig_seq_pkg::probe_cmp_t  [trig_seq_pkg::NUM_CMP-1:0]    PROBE_CMP,
	input  trig_seq_pkg::cnt_cmp_t    [trig_seq_pkg::NUM_CNT-1:0]    CNT_CMP,
	// Trigger and status
	output logic                               TRIGGER,
	output logic                               HALTED,
	output logic [trig_seq_pkg::STATE_W-1:0]   STATE_INDEX,
	output logic                               STATUS_MARK_A,
	output logic                               STATUS_MARK_B,
	output logic                               STATUS_MARK_C,
	output logic                               STATUS_MARK_D,
	output logic [trig_seq_pkg::CNT_W-1:0]     EVENT_COUNT_A,
	output logic [trig_seq_pkg::CNT_W-1:0]     EVENT_COUNT_B,
	output logic [trig_seq_pkg::CNT_W-1:0]     EVENT_COUNT_C,
	output logic [trig_seq_pkg::CNT_W-1:0]     EVENT_COUNT_D
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	trig_seq_pkg::seq_t                      seq_ff;
	trig_seq_pkg::seq_t                      nxt_seq;
	logic [trig_seq_pkg::STATE_W-1:0]        state_ff;
	logic [trig_seq_pkg::NUM_CNT-1:0]
	      [trig_seq_pkg::CNT_W-1:0]          count_ff;
	logic [trig_seq_pkg::NUM_FLAGS-1:0]      flag_ff;
	logic                                    trigger_ff;
	logic [trig_seq_pkg::NUM_PROBES-1:0]
	      [trig_seq_pkg::PROBE_W-1:0]        prev_ff;
	logic                                    prev_valid_ff;
	logic [trig_seq_pkg::NUM_CMP-1:0]        probe_hit;
	logic [trig_seq_pkg::NUM_CNT-1:0]        cnt_hit;
	trig_seq_pkg::state_prog_t               cur;
	logic                                    first_true;
	logic                                    second_true;
	trig_seq_pkg::action_t                   act;
	logic                                    step;
	logic                                    fire;
	logic                                    advance;
	logic                                    halted_ff;

	// ****************************************************************
	// Probe comparators
	// ****************************************************************
	// Relations are unsigned on the masked values
	// (R11) one comparator per probe condition
	// (R12) fixed comparator count per probe port
	for (genvar i = 0; i < trig_seq_pkg::NUM_CMP; i++)
	begin : g_probe_cmp
		localparam int PORT = i / trig_seq_pkg::CMP_PER_PROBE;
		logic [trig_seq_pkg::PROBE_W-1:0] mask;
		logic [trig_seq_pkg::PROBE_W-1:0] seen;
		logic [trig_seq_pkg::PROBE_W-1:0] want;
		logic                             now_bit;
		logic                             old_bit;

		assign mask    = PROBE_CMP[i].care;
		assign seen    = PROBE[PORT] & mask;
		assign want    = PROBE_CMP[i].value & mask;
		// Edge tests look only at the edge bit of the port
		assign now_bit = PROBE[PORT][trig_seq_pkg::EDGE_BIT];
		assign old_bit = prev_ff[PORT][trig_seq_pkg::EDGE_BIT];

		always_comb
		begin
			// (R13) six relations, don't-care bits masked
			// (R14) care mask gives per-bit don't-care
			// (R15) edge tests on the single probe bit
			case (PROBE_CMP[i].op)
				trig_seq_pkg::CMP_EQ:     probe_hit[i] = (seen == want);
				trig_seq_pkg::CMP_NE:     probe_hit[i] = (seen != want);
				trig_seq_pkg::CMP_GT:     probe_hit[i] = (seen > want);
				trig_seq_pkg::CMP_LT:     probe_hit[i] = (seen < want);
				trig_seq_pkg::CMP_GE:     probe_hit[i] = (seen >= want);
				trig_seq_pkg::CMP_LE:     probe_hit[i] = (seen <= want);
				trig_seq_pkg::CMP_RISE:
					probe_hit[i] = prev_valid_ff & ~old_bit & now_bit;
				trig_seq_pkg::CMP_FALL:
					probe_hit[i] = prev_valid_ff & old_bit & ~now_bit;
				trig_seq_pkg::CMP_EITHER:
					probe_hit[i] = prev_valid_ff & (old_bit ^ now_bit);
				trig_seq_pkg::CMP_STEADY:
					probe_hit[i] = prev_valid_ff & (old_bit == now_bit);
				default:                  probe_hit[i] = 1'b0;
			endcase
		end
	end

	// Previous sample for transition detection
	// No edge is reported until a first sample exists
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
		begin
			prev_ff       <= '{default: trig_seq_pkg::PROBE_IDLE};
			prev_valid_ff <= 1'b0;
		end
		else
		begin
			prev_ff       <= PROBE;
			prev_valid_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// Counter comparators
	// ****************************************************************
	// Inverting on ne gives both relations from one equality
	for (genvar c = 0; c < trig_seq_pkg::NUM_CNT; c++)
	begin : g_cnt_cmp
		// (R16) single comparator per counter
		// (R17) equal or not equal only
		assign cnt_hit[c] = CNT_CMP[c].ne ^
		                    (count_ff[c] == CNT_CMP[c].value);
	end

	// ****************************************************************
	// Condition evaluation
	// ****************************************************************
	function automatic logic eval_cond(
		input trig_seq_pkg::cond_t              cnd,
		input logic [trig_seq_pkg::NUM_CMP-1:0] hits,
		input logic [trig_seq_pkg::NUM_CNT-1:0] chits
	);
		logic any_probe;
		logic probe_res;
		logic cnt_res;
		any_probe = |cnd.probe_sel;
		// (R18) one common operator among probe terms
		probe_res = cnd.probe_or ? |(cnd.probe_sel & hits)
		                         : &(~cnd.probe_sel | hits);
		cnt_res   = chits[cnd.cnt_sel];
		// (R19) probe result joined with counter test
		if (any_probe && cnd.cnt_en)
			eval_cond = cnd.cnt_or ? (probe_res | cnt_res)
			                       : (probe_res & cnt_res);
		else if (any_probe)
			eval_cond = probe_res;
		else if (cnd.cnt_en)
			eval_cond = cnt_res;
		// Empty condition never holds
		else
			eval_cond = 1'b0;
	endfunction

	// ****************************************************************
	// Current program entry
	// ****************************************************************
	// Program is read live; an edit acts on the next step
	// (R1) program of up to sixteen states
	assign cur         = PROGRAM[state_ff];
	assign first_true  = eval_cond(cur.cond_first, probe_hit, cnt_hit);
	assign second_true = eval_cond(cur.cond_second, probe_hit, cnt_hit);

	// ****************************************************************
	// Branch selection
	// ****************************************************************
	always_comb
	begin
		// (R2) one, two or three way branching
		case (cur.kind)
			trig_seq_pkg::BR_ONE:
				act = cur.act_first;
			// (R3) first target or alternative
			trig_seq_pkg::BR_TWO:
				act = first_true ? cur.act_first : cur.act_default;
			// (R4) priority first, then second, else default
			trig_seq_pkg::BR_THREE:
				if (first_true)
					act = cur.act_first;
				else if (second_true)
					act = cur.act_second;
				else
					act = cur.act_default;
			// Unused kind code falls back to the default block
			default:
				act = cur.act_default;
		endcase
	end

	// Arming overrides the program for the whole cycle
	// (R20) one step per sample while running
	assign step = (seq_ff == trig_seq_pkg::SEQ_RUN) && !ARM;
	// Triggering block ends the run; its target is ignored
	assign fire    = step && act.trigger;
	assign advance = step && !act.trigger;

	// ****************************************************************
	// Sequencer run control
	// ****************************************************************
	always_comb
	begin
		nxt_seq = seq_ff;
		case (seq_ff)
			trig_seq_pkg::SEQ_RUN:
				// (R21) stop after trigger
				if (fire)
					nxt_seq = trig_seq_pkg::SEQ_HALT;
			trig_seq_pkg::SEQ_HALT:
				if (ARM)
					nxt_seq = trig_seq_pkg::SEQ_RUN;
			// Illegal run code recovers to running
			default:
				nxt_seq = trig_seq_pkg::SEQ_RUN;
		endcase
	end

	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			seq_ff <= trig_seq_pkg::SEQ_RUN;
		else
			seq_ff <= nxt_seq;
	end

	// ****************************************************************
	// Halt indication
	// ****************************************************************
	// Own flop so the output needs no decode of the run state
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			halted_ff <= 1'b0;
		// (R21) held from trigger until re-armed
		else
			halted_ff <= (nxt_seq == trig_seq_pkg::SEQ_HALT);
	end

	// ****************************************************************
	// Current state
	// ****************************************************************
	always_ff @(posedge CLK)
	begin
		// (R20) restart at first state
		if (!RESET_N || ARM)
			state_ff <= trig_seq_pkg::FIRST_STATE;
		// (R5) goto moves to target unless block triggers
		else if (advance)
			state_ff <= act.target;
	end

	// ****************************************************************
	// Trigger output
	// ****************************************************************
	always_ff @(posedge CLK)
	begin
		if (!RESET_N)
			trigger_ff <= 1'b0;
		// (R21) one-cycle trigger pulse
		// Halt blocks a second pulse on the next cycle
		else
			trigger_ff <= fire;
	end

	// ****************************************************************
	// Event counters
	// ****************************************************************
	// Counters wrap silently; no overflow is flagged
	// (R6) four 16-bit counters, wrapping
	for (genvar c = 0; c < trig_seq_pkg::NUM_CNT; c++)
	begin : g_counter
		always_ff @(posedge CLK)
		begin
			if (!RESET_N || ARM)
				count_ff[c] <= trig_seq_pkg::CNT_ZERO;
			// (R7) clear to zero, wins over increment
			else if (step && act.cnt_clr[c])
				count_ff[c] <= trig_seq_pkg::CNT_ZERO;
			// (R8) add one
			else if (step && act.cnt_inc[c])
				count_ff[c] <= count_ff[c] + trig_seq_pkg::CNT_ONE;
		end
	end

	// ****************************************************************
	// Status flags
	// ****************************************************************
	// Clear acts only where no set is requested
	// (R9) individual set and clear, set wins
	for (genvar f = 0; f < trig_seq_pkg::NUM_FLAGS; f++)
	begin : g_flag
		always_ff @(posedge CLK)
		begin
			if (!RESET_N || ARM)
				flag_ff[f] <= trig_seq_pkg::FLAGS_IDLE[f];
			else if (step && act.flag_set[f])
				flag_ff[f] <= 1'b1;
			else if (step && act.flag_clr[f])
				flag_ff[f] <= 1'b0;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Every output is a flop, no logic after it
	assign TRIGGER       = trigger_ff;
	assign HALTED        = halted_ff;
	assign STATE_INDEX   = state_ff;
	// (R10) flags visible outside
	assign STATUS_MARK_A = flag_ff[0];
	assign STATUS_MARK_B = flag_ff[1];
	assign STATUS_MARK_C = flag_ff[2];
	assign STATUS_MARK_D = flag_ff[3];
	assign EVENT_COUNT_A = count_ff[0];
	assign EVENT_COUNT_B = count_ff[1];
	assign EVENT_COUNT_C = count_ff[2];
	assign EVENT_COUNT_D = count_ff[3];

endmodule // trigger_state_sequencer

//--- verif/trig_seq_sva.sv
// Property checker for the trigger state sequencer
module trig_seq_sva (
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RESET_N,
	// Control
	input wire logic        ARM,
	// Observed outputs
	input wire logic        TRIGGER,
	input wire logic        HALTED,
	input wire logic [3:0]  STATE_INDEX,
	input wire logic        STATUS_MARK_A,
	input wire logic        STATUS_MARK_B,
	input wire logic        STATUS_MARK_C,
	input wire logic        STATUS_MARK_D,
	input wire logic [15:0] EVENT_COUNT_A
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);
	wire logic [3:0] marks = {STATUS_MARK_D, STATUS_MARK_C,
		STATUS_MARK_B, STATUS_MARK_A};

	a_trig_pulse: assert property (TRIGGER |=> !TRIGGER)
		else $error("trigger longer than one cycle");
	a_trig_halts: assert property (TRIGGER |-> HALTED)
		else $error("trigger without halt");
	a_halt_cause: assert property ($rose(HALTED) |-> TRIGGER)
		else $error("halt without trigger");
	a_halt_state: assert property (
		HALTED && !ARM |=> $stable(STATE_INDEX) && HALTED)
		else $error("halted sequencer moved");
	a_halt_frozen: assert property (
		HALTED && !ARM |=> $stable(EVENT_COUNT_A) && $stable(marks))
		else $error("halted sequencer changed counter or flag");
	a_arm_restart: assert property (ARM |=>
		STATE_INDEX == 4'h0 && !HALTED && marks == 4'h0
		&& EVENT_COUNT_A == 16'h0000)
		else $error("arming did not restart");
	a_count_step: assert property (
		$changed(EVENT_COUNT_A) |->
		EVENT_COUNT_A == $past(EVENT_COUNT_A) + 16'h0001
		|| EVENT_COUNT_A == 16'h0000)
		else $error("counter moved other than by one or to zero");
	a_arm_quiet: assert property (ARM |=> !TRIGGER)
		else $error("trigger while armed");

	c_trigger: cover property (TRIGGER);
	c_restart: cover property (HALTED ##1 ARM);
	c_count: cover property (EVENT_COUNT_A == 16'h0001);
endmodule // trig_seq_sva

bind trigger_state_sequencer trig_seq_sva i_trig_seq_sva (
	.CLK(CLK), .RESET_N(RESET_N), .ARM(ARM), .TRIGGER(TRIGGER),
	.HALTED(HALTED), .STATE_INDEX(STATE_INDEX),
	.STATUS_MARK_A(STATUS_MARK_A), .STATUS_MARK_B(STATUS_MARK_B),
	.STATUS_MARK_C(STATUS_MARK_C), .STATUS_MARK_D(STATUS_MARK_D),
	.EVENT_COUNT_A(EVENT_COUNT_A));

//--- verif/user_probe_model.sv
// Model of the user logic that feeds the probe ports
module user_probe_model (
	// Clock
	input wire logic             CLK,
	// Value for the next cycle
	input wire logic [1:0][7:0]  VALUE,
	// Probed signals
	output logic     [1:0][7:0]  PROBE
);
	timeunit 1ns;
	timeprecision 1ns;
	// User logic changes just after its clock edge
	initial
	begin
		PROBE = 16'h0000;
		forever
			@(posedge CLK) PROBE <= #1 VALUE;
	end
endmodule // user_probe_model

//--- verif/trigger_state_sequencer_tb_top.sv
// Self-checking testbench of the trigger state sequencer
module trigger_state_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                              clk = 1'b0;
	logic                              reset_n = 1'b0;
	logic                              arm = 1'b0;
	logic [1:0][7:0]                   value = 16'h0000;
	wire logic [1:0][7:0]              probe;
	trig_seq_pkg::state_prog_t [15:0]  prog = '0;
	trig_seq_pkg::probe_cmp_t [3:0]    pcmp = '0;
	trig_seq_pkg::cnt_cmp_t [3:0]      ccmp = '0;
	wire logic                         trigger;
	wire logic                         halted;
	wire logic [3:0]                   state_index;
	wire logic [3:0]                   marks;
	wire logic [3:0][15:0]             counts;
	int                                num_errors = 0;
	int                                compares = 0;
	int                                cycles = 0;
	logic [7:0]                        pv;
	logic                              hit;

	always #50 clk = ~clk;

	user_probe_model i_user_probe_model (.CLK(clk), .VALUE(value),
		.PROBE(probe));

	trigger_state_sequencer i_trigger_state_sequencer (.CLK(clk),
		.RESET_N(reset_n), .ARM(arm), .PROBE(probe), .PROGRAM(prog),
		.PROBE_CMP(pcmp), .CNT_CMP(ccmp), .TRIGGER(trigger),
		.HALTED(halted), .STATE_INDEX(state_index),
		.STATUS_MARK_A(marks[0]), .STATUS_MARK_B(marks[1]),
		.STATUS_MARK_C(marks[2]), .STATUS_MARK_D(marks[3]),
		.EVENT_COUNT_A(counts[0]), .EVENT_COUNT_B(counts[1]),
		.EVENT_COUNT_C(counts[2]), .EVENT_COUNT_D(counts[3]));

	task automatic report_and_stop();
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, got);
			num_errors++;
		end
	endtask

	task automatic restart(input logic [15:0] v);
		value = v;
		arm = 1'b1;
		step();
		arm = 1'b0;
	endtask

	function automatic trig_seq_pkg::cond_t mkc(input logic [3:0] sel,
		input logic por, input logic cen, input logic cor);
		mkc = '0;
		mkc.probe_sel = sel;
		mkc.probe_or = por;
		mkc.cnt_en = cen;
		mkc.cnt_sel = 2'h1;
		mkc.cnt_or = cor;
	endfunction

	// State 0 hands over to state 3, which branches to 1, 4 or 2
	task automatic branch(input trig_seq_pkg::branch_t k,
		input trig_seq_pkg::cond_t c1, input trig_seq_pkg::cond_t c2,
		input logic [15:0] p0, input logic [15:0] p1,
		input logic [3:0] exp);
		prog[3].kind = k;
		prog[3].cond_first = c1;
		prog[3].cond_second = c2;
		restart(p0);
		value = p1;
		step();
		step();
		chk("branch state", exp, state_index);
	endtask

	task automatic test_relations();
		for (int i = 0; i < 6; i++)
			for (int j = 0; j < 3; j++)
			begin
				pv = 8'h0F + 8'(j);
				pcmp[0] = '{trig_seq_pkg::cmp_op_t'(i), 8'h10, 8'hFF};
				case (i)
					0: hit = pv == 8'h10;
					1: hit = pv != 8'h10;
					2: hit = pv > 8'h10;
					3: hit = pv < 8'h10;
					4: hit = pv >= 8'h10;
					default: hit = pv <= 8'h10;
				endcase
				branch(trig_seq_pkg::BR_TWO, mkc(4'h1, 1'b0, 1'b0, 1'b0), '0,
					{8'h00, pv}, {8'h00, pv}, hit ? 4'h1 : 4'h2);
			end
		pcmp[0] = '{trig_seq_pkg::CMP_EQ, 8'h10, 8'hF0};
		branch(trig_seq_pkg::BR_TWO, mkc(4'h1, 1'b0, 1'b0, 1'b0), '0,
			16'h001F, 16'h001F, 4'h1);
	endtask

	task automatic test_edges();
		for (int i = 0; i < 4; i++)
			for (int j = 0; j < 4; j++)
			begin
				pcmp[2] = '{trig_seq_pkg::cmp_op_t'(6 + i), 8'h00, 8'hFF};
				case (i)
					0: hit = !j[1] && j[0];
					1: hit = j[1] && !j[0];
					2: hit = j[1] ^ j[0];
					default: hit = j[1] == j[0];
				endcase
				branch(trig_seq_pkg::BR_TWO, mkc(4'h4, 1'b0, 1'b0, 1'b0), '0,
					{7'h00, j[1], 8'h00}, {7'h00, j[0], 8'h00},
					hit ? 4'h1 : 4'h2);
			end
	endtask

	task automatic test_combine();
		pcmp[0] = '{trig_seq_pkg::CMP_GE, 8'h10, 8'hFF};
		pcmp[1] = '{trig_seq_pkg::CMP_LE, 8'h20, 8'hFF};
		ccmp[1] = '{1'b1, 16'h0000};
		branch(trig_seq_pkg::BR_TWO, mkc(4'h3, 1'b0, 1'b0, 1'b0), '0,
			16'h0030, 16'h0030, 4'h2);
		branch(trig_seq_pkg::BR_TWO, mkc(4'h3, 1'b1, 1'b0, 1'b0), '0,
			16'h0030, 16'h0030, 4'h1);
		branch(trig_seq_pkg::BR_TWO, mkc(4'h1, 1'b0, 1'b1, 1'b0), '0,
			16'h0030, 16'h0030, 4'h2);
		branch(trig_seq_pkg::BR_TWO, mkc(4'h1, 1'b0, 1'b1, 1'b1), '0,
			16'h0030, 16'h0030, 4'h1);
		ccmp[1] = '{1'b0, 16'h0000};
		branch(trig_seq_pkg::BR_TWO, mkc(4'h0, 1'b0, 1'b1, 1'b0), '0,
			16'h0005, 16'h0005, 4'h1);
		branch(trig_seq_pkg::BR_THREE, mkc(4'h1, 1'b0, 1'b0, 1'b0),
			mkc(4'h0, 1'b0, 1'b1, 1'b0), 16'h0030, 16'h0030,
			4'h1);
		branch(trig_seq_pkg::BR_THREE, mkc(4'h1, 1'b0, 1'b0, 1'b0),
			mkc(4'h0, 1'b0, 1'b1, 1'b0), 16'h0005, 16'h0005,
			4'h4);
		ccmp[1] = '{1'b1, 16'h0000};
		branch(trig_seq_pkg::BR_THREE, mkc(4'h1, 1'b0, 1'b0, 1'b0),
			mkc(4'h0, 1'b0, 1'b1, 1'b0), 16'h0005, 16'h0005,
			4'h2);
		branch(trig_seq_pkg::BR_ONE, '0, '0, 16'h0005, 16'h0005,
			4'h1);
	endtask

	task automatic test_counters();
		logic [3:0][15:0] e;
		e = {16'h0001, 16'h0001, 16'h0003, 16'h0000};
		prog[0].act_first = '{4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 4'h5};
		prog[5].kind = trig_seq_pkg::BR_TWO;
		prog[5].cond_first = mkc(4'h0, 1'b0, 1'b1, 1'b0);
		prog[5].act_first = '{4'h1, 4'h0, 4'hA, 4'h0, 1'b0, 4'h6};
		prog[5].act_default = '{4'h0, 4'h2, 4'h0, 4'h0, 1'b0, 4'h5};
		prog[6].act_first = '{4'h0, 4'h0, 4'h0, 4'h2, 1'b1, 4'h0};
		ccmp[1] = '{1'b0, 16'h0003};
		restart(16'h0000);
		repeat (4) step();
		chk("state", 4'h6, state_index);
		chk("flags", 4'hA, marks);
		for (int k = 0; k < 4; k++)
			chk("count", e[k], counts[k]);
		step();
		chk("trigger", 1'b1, trigger);
		chk("halted", 1'b1, halted);
		chk("flags", 4'h8, marks);
		chk("state", 4'h6, state_index);
		step();
		chk("trigger", 1'b0, trigger);
		chk("halted", 1'b1, halted);
		restart(16'h0000);
		chk("halted", 1'b0, halted);
		chk("state", 4'h0, state_index);
		chk("count", 16'h0000, counts[1]);
	endtask

	// Reset in mid-run, then the program must start over
	task automatic test_reset();
		restart(16'h0000);
		step();
		chk("count", 16'h0001, counts[2]);
		reset_n = 1'b0;
		step();
		reset_n = 1'b1;
		chk("state", 4'h0, state_index);
		chk("count", 16'h0000, counts[2]);
		chk("trigger", 1'b0, trigger);
		step();
		chk("state", 4'h5, state_index);
		chk("count", 16'h0001, counts[0]);
	endtask

	initial
	begin
		prog[0].act_first.target = 4'h3;
		prog[3].act_first.target = 4'h1;
		prog[3].act_second.target = 4'h4;
		prog[3].act_default.target = 4'h2;
		repeat (5) @(posedge clk);
		#1;
		reset_n = 1'b1;
		chk("state", 4'h0, state_index);
		chk("trigger", 1'b0, trigger);
		chk("count", 16'h0000, counts[3]);
		test_relations();
		test_edges();
		test_combine();
		test_counters();
		test_reset();
		report_and_stop();
	end
endmodule // trigger_state_sequencer_tb_top
